// file: pkg/efcr_regs.svh
// Feature addresses, field positions, codes and reset values of the flip count report
`ifndef EFCR_REGS_SVH
`define EFCR_REGS_SVH

// ----------------------------------------------------------------------------
// Feature addresses
// ----------------------------------------------------------------------------
`define EFCR_FA_THRESH_FLAGS 8'h20
`define EFCR_FA_PAGE_WORST   8'h30
`define EFCR_FA_COUNT_LOW    8'h40
`define EFCR_FA_COUNT_HIGH   8'h50

// ----------------------------------------------------------------------------
// Field positions and codes
// ----------------------------------------------------------------------------
`define EFCR_SECTORS         4
`define EFCR_WORST_MAX_LSB   4
`define EFCR_CODE_NONE       4'h0
`define EFCR_CODE_UNCORR     4'hF
`define EFCR_MAX_CORRECTED   8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define EFCR_RST_BYTE        8'h00
`define EFCR_RST_FLAGS       4'h0

`endif

// file: pkg/efcr_pkg.sv
// Types shared by the flip count report modules
package efcr_pkg;
  typedef logic [3:0] efcr_code_type;   // 4-bit flip count code
  typedef logic [1:0] efcr_index_type;  // Sector number 0..3
  typedef logic [7:0] efcr_byte_type;   // Feature address or data byte
endpackage

// file: pkg/efcr_grade_if.sv
// Carrier between the report core and one sector grader
`timescale 1ns/1ps
interface efcr_grade_if #(
  parameter int RAW_W = 5
);
  logic [RAW_W-1:0]       raw;     // Held corrected flip count
  efcr_pkg::efcr_code_type thresh; // Threshold setting
  efcr_pkg::efcr_code_type code;   // Encoded 4-bit report
  logic                   hit;     // Code at or above threshold

  modport grader (input raw, input thresh, output code, output hit);
  modport user   (output raw, output thresh, input code, input hit);
endinterface

// file: rtl/efcr_sector_grade.sv
// Encodes one sector's flip count and compares it with the threshold
`timescale 1ns/1ps
`include "efcr_regs.svh"
module efcr_sector_grade #(
  parameter int RAW_W = 5
) (
  input  wire logic    core_clk, // Clock, used by checks only
  input  wire logic    rst_b,    // Synchronous reset, active low
  efcr_grade_if.grader g         // Count in, code and flag out
);

  // ----------------------------------------------------------------------------
  // Encoding and threshold compare
  // ----------------------------------------------------------------------------
  // Zero stays zero, 1..8 pass through, anything beyond saturates to all ones
  always_comb begin
    if (g.raw > RAW_W'(`EFCR_MAX_CORRECTED)) begin
      g.code = `EFCR_CODE_UNCORR;
    end else begin
      g.code = efcr_pkg::efcr_code_type'(g.raw);
    end
  end

  // All-ones threshold then only catches uncorrectable sectors
  assign g.hit = (g.code >= g.thresh);

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  chk_code_saturate: assert property (@(posedge core_clk) disable iff (!rst_b)
    (g.raw > RAW_W'(`EFCR_MAX_CORRECTED)) |-> (g.code == `EFCR_CODE_UNCORR))
    else $error("uncorrectable sector not reported as all ones");

  chk_code_exact: assert property (@(posedge core_clk) disable iff (!rst_b)
    (g.raw <= RAW_W'(`EFCR_MAX_CORRECTED)) |-> (RAW_W'(g.code) == g.raw))
    else $error("corrected flip count encoded wrongly");

  // Judged from the raw count, so a broken encoder or compare both show up
  chk_hit_compare: assert property (@(posedge core_clk) disable iff (!rst_b)
    g.hit == ((g.raw > RAW_W'(`EFCR_MAX_CORRECTED)) || (g.raw >= RAW_W'(g.thresh))))
    else $error("threshold flag disagrees with count");

endmodule

// file: rtl/efcr_report.sv
// Flip count report core: per-sector flags, counts and page worst sector
`timescale 1ns/1ps
`include "efcr_regs.svh"
module efcr_report #(
  parameter int RAW_W = 5
) (
  input  wire logic                           core_clk,               // 10 MHz clock
  input  wire logic                           rst_b,                  // Synchronous reset, active low
  input  wire logic [3:0]                     flip_threshold_setting, // Threshold nibble
  input  wire logic [`EFCR_SECTORS*RAW_W-1:0] sector_raw_count,       // Corrected counts, sector 0 low
  input  wire logic                           page_load_done,         // ECC page load finished, pulse
  input  wire logic                           buffer_read_done,       // Buffer read finished, pulse
  input  wire logic [7:0]                     feat_addr,              // Feature address
  input  wire logic                           feat_rd,                // Feature read strobe
  input  wire logic                           feat_wr,                // Feature write strobe
  input  wire logic [7:0]                     feat_wdata,             // Feature write data
  output logic      [7:0]                     feat_rdata,             // Read data, registered
  output logic                                feat_rvalid,            // Read data valid, pulse
  output logic                                feat_wack,              // Write taken, pulse
  output logic      [3:0]                     sector_threshold_flag   // Per-sector flags
);

  // ----------------------------------------------------------------------------
  // Held state
  // ----------------------------------------------------------------------------
  logic [RAW_W-1:0]         raw_q [`EFCR_SECTORS];   // Counts of the last checked page
  logic [3:0]               flags_q;                 // Threshold flags
  efcr_pkg::efcr_byte_type  rdata_q;
  efcr_pkg::efcr_byte_type  rdata_d;
  logic                     rvalid_q;
  logic                     wack_q;
  efcr_pkg::efcr_code_type  code_w [`EFCR_SECTORS]; // Encoded codes
  logic [3:0]               hit_w;                   // Compare results
  logic [15:0]              count_report;            // Packed codes
  efcr_pkg::efcr_code_type  max_code;
  efcr_pkg::efcr_index_type max_idx;
  efcr_pkg::efcr_byte_type  worst_byte;
  logic                     tie_ok;                  // Check helper

  efcr_grade_if #(.RAW_W(RAW_W)) gi [`EFCR_SECTORS] ();

  // ----------------------------------------------------------------------------
  // One grader per sector
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < `EFCR_SECTORS; i++) begin : g_sector
    assign gi[i].raw    = raw_q[i];
    assign gi[i].thresh = flip_threshold_setting;
    assign code_w[i]    = gi[i].code;
    assign hit_w[i]     = gi[i].hit;

    efcr_sector_grade #(
      .RAW_W (RAW_W)
    ) u_grade (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .g        (gi[i])
    );
  end

  // ----------------------------------------------------------------------------
  // Capture of the page counts
  // ----------------------------------------------------------------------------
  // Only the ECC page load refreshes counts; host accesses never touch them
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      for (int i = 0; i < `EFCR_SECTORS; i++) begin
        raw_q[i] <= '0;
      end
    end else if (page_load_done) begin
      for (int i = 0; i < `EFCR_SECTORS; i++) begin
        raw_q[i] <= sector_raw_count[i*RAW_W +: RAW_W];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Threshold flags
  // ----------------------------------------------------------------------------
  // Compared at the buffer read so a threshold changed after the load counts
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flags_q <= `EFCR_RST_FLAGS;
    end else if (buffer_read_done) begin
      flags_q <= hit_w;
    end
  end

  // ----------------------------------------------------------------------------
  // Packed counts and page maximum
  // ----------------------------------------------------------------------------
  assign count_report = {code_w[3], code_w[2], code_w[1], code_w[0]};

  // Strictly-greater scan from sector 0 keeps the lowest index on a tie
  always_comb begin
    max_code = code_w[0];
    max_idx  = '0;
    for (int i = 1; i < `EFCR_SECTORS; i++) begin
      if (code_w[i] > max_code) begin
        max_code = code_w[i];
        max_idx  = efcr_pkg::efcr_index_type'(i);
      end
    end
  end

  // Reserved bits 3 and 2 read zero; the index fills bits 1 to 0
  assign worst_byte = {max_code, 1'b0, 1'b0, max_idx};

  // ----------------------------------------------------------------------------
  // Feature read port
  // ----------------------------------------------------------------------------
  // Unmapped addresses read zero rather than stale data
  always_comb begin
    unique case (feat_addr)
      `EFCR_FA_THRESH_FLAGS: rdata_d = {4'h0, flags_q};
      `EFCR_FA_PAGE_WORST:   rdata_d = worst_byte;
      `EFCR_FA_COUNT_LOW:    rdata_d = count_report[7:0];
      `EFCR_FA_COUNT_HIGH:   rdata_d = count_report[15:8];
      default:               rdata_d = `EFCR_RST_BYTE;
    endcase
  end

  // Data is held after the read so slow hosts may sample late
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata_q  <= `EFCR_RST_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= feat_rd;
      if (feat_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Feature write port
  // ----------------------------------------------------------------------------
  // Every field is status only: the write is acknowledged and the data dropped
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wack_q <= 1'b0;
    end else begin
      wack_q <= feat_wr & (feat_wdata == feat_wdata);
    end
  end

  assign feat_rdata            = rdata_q;
  assign feat_rvalid           = rvalid_q;
  assign feat_wack             = wack_q;
  assign sector_threshold_flag = flags_q;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  // Every lower sector must be strictly below the reported maximum
  always_comb begin
    tie_ok = (code_w[max_idx] == max_code);
    for (int i = 0; i < `EFCR_SECTORS; i++) begin
      if (efcr_pkg::efcr_index_type'(i) < max_idx && code_w[i] >= max_code) begin
        tie_ok = 1'b0;
      end
    end
  end

  chk_flag_update: assert property (@(posedge core_clk) disable iff (!rst_b)
    buffer_read_done |=> (flags_q == $past(hit_w)))
    else $error("flags not updated at buffer read");

  chk_flag_no_load: assert property (@(posedge core_clk) disable iff (!rst_b)
    (page_load_done && !buffer_read_done) |=> $stable(flags_q))
    else $error("flags changed by page load");

  chk_low_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
    (feat_rd && feat_addr == `EFCR_FA_COUNT_LOW) |=>
      (feat_rvalid && feat_rdata == {$past(code_w[1]), $past(code_w[0])}))
    else $error("low count byte wrong");

  chk_high_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
    (feat_rd && feat_addr == `EFCR_FA_COUNT_HIGH) |=>
      (feat_rvalid && feat_rdata == {$past(code_w[3]), $past(code_w[2])}))
    else $error("high count byte wrong");

  chk_worst_max: assert property (@(posedge core_clk) disable iff (!rst_b)
    (max_code >= code_w[0]) && (max_code >= code_w[1]) &&
    (max_code >= code_w[2]) && (max_code >= code_w[3]))
    else $error("page maximum below a sector count");

  chk_worst_tie: assert property (@(posedge core_clk) disable iff (!rst_b)
    tie_ok)
    else $error("worst sector index not lowest of ties");

  chk_worst_read: assert property (@(posedge core_clk) disable iff (!rst_b)
    (feat_rd && feat_addr == `EFCR_FA_PAGE_WORST) |=>
      (feat_rdata[7:4] == $past(max_code) && feat_rdata[1:0] == $past(max_idx) && feat_rdata[3:2] == 2'h0))
    else $error("page worst byte wrong");

  chk_count_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
    !page_load_done |=> (raw_q[0] == $past(raw_q[0]) && raw_q[3] == $past(raw_q[3])))
    else $error("counts changed without a page load");

  chk_write_inert: assert property (@(posedge core_clk) disable iff (!rst_b)
    (feat_wr && !page_load_done && !buffer_read_done) |=> (feat_wack && $stable(flags_q) && $stable(max_code)))
    else $error("write disturbed status");

endmodule

// file: sim/efcr_host_model.sv
// Host controller model issuing feature reads and writes
`timescale 1ns/1ps
module efcr_host_model (
  input  wire logic       core_clk,    // Device clock
  output logic      [7:0] feat_addr,   // Feature address
  output logic            feat_rd,     // Read request
  output logic            feat_wr,     // Write request
  output logic      [7:0] feat_wdata,  // Write data
  input  wire logic [7:0] feat_rdata,  // Read data
  input  wire logic       feat_rvalid, // Read data valid
  input  wire logic       feat_wack    // Write taken
);
  // Idle bus; requests launch on the falling edge
  initial begin
    feat_addr  = 8'h00;
    feat_rd    = 1'b0;
    feat_wr    = 1'b0;
    feat_wdata = 8'h00;
  end

  // One read; address scrambled after release so stale values never help
  task automatic read(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge core_clk);
    feat_addr = a;
    feat_rd = 1'b1;
    @(negedge core_clk);
    feat_rd = 1'b0;
    feat_addr = ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (feat_rvalid === 1'b1) begin
        ok = 1'b1;
        d = feat_rdata;
      end else begin
        @(negedge core_clk);
      end
    end
    // Reserved bit 3 of the worst byte and flag bits 7:4 may read either way, so they are dropped
    if (a == 8'h30) d[3] = 1'b0;
    if (a == 8'h20) d[7:4] = 4'h0;
  endtask

  // One write of zeros to a status address
  task automatic write(input logic [7:0] a, output bit ok);
    ok = 1'b0;
    @(negedge core_clk);
    feat_addr = a;
    feat_wdata = 8'h00;
    feat_wr = 1'b1;
    @(negedge core_clk);
    feat_wr = 1'b0;
    feat_addr = ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (feat_wack === 1'b1) ok = 1'b1;
      else @(negedge core_clk);
    end
  endtask
endmodule

// file: sim/tb_top.sv
// Self-checking bench for the flip count report
`timescale 1ns/1ps
module tb_top;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  thr = 4'h4;
  logic [19:0] raw = 20'h0;
  logic        load = 1'b0;
  logic        bufrd = 1'b0;
  logic [7:0]  feat_addr, feat_wdata, feat_rdata;
  logic        feat_rd, feat_wr, feat_rvalid, feat_wack;
  logic [3:0]  flags;
  int          mismatches = 0;
  int          n_compared = 0;

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  efcr_report efcr_report_inst (.core_clk(core_clk), .rst_b(rst_b), .flip_threshold_setting(thr),
    .sector_raw_count(raw), .page_load_done(load), .buffer_read_done(bufrd), .feat_addr(feat_addr),
    .feat_rd(feat_rd), .feat_wr(feat_wr), .feat_wdata(feat_wdata), .feat_rdata(feat_rdata),
    .feat_rvalid(feat_rvalid), .feat_wack(feat_wack), .sector_threshold_flag(flags));
  efcr_host_model efcr_host_model_inst (.core_clk(core_clk), .feat_addr(feat_addr), .feat_rd(feat_rd),
    .feat_wr(feat_wr), .feat_wdata(feat_wdata), .feat_rdata(feat_rdata), .feat_rvalid(feat_rvalid),
    .feat_wack(feat_wack));

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic test_done();
    $display("Counts: %0d compared, %0d mismatched", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // A read that times out ends the run
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string msg);
    logic [7:0] d;
    bit ok;
    efcr_host_model_inst.read(a, d, ok);
    if (!ok) begin
      mismatches++;
      test_done();
    end
    chk(d, exp, msg);
  endtask

  // Expected code: beyond eight flips means uncorrected
  function automatic logic [3:0] code(input logic [4:0] r);
    return (r > 5'd8) ? 4'hF : r[3:0];
  endfunction

  // Load one page, read the reports, then latch flags with threshold t
  task automatic page(input logic [4:0] r0, r1, r2, r3, input logic [3:0] t);
    logic [3:0] c[4];
    logic [3:0] mx;
    logic [2:0] ix;
    logic [3:0] f;
    logic [3:0] old;
    c = '{code(r0), code(r1), code(r2), code(r3)};
    mx = 4'h0;
    ix = 3'd0;
    old = flags;
    for (int i = 0; i < 4; i++) begin
      if (c[i] > mx) begin
        mx = c[i];
        ix = 3'(i);
      end
      f[i] = (c[i] >= t);
    end
    @(negedge core_clk);
    raw = {r3, r2, r1, r0};
    load = 1'b1;
    @(negedge core_clk);
    load = 1'b0;
    raw = ~raw;
    rd(8'h40, {c[1], c[0]}, "low counts");
    rd(8'h50, {c[3], c[2]}, "high counts");
    rd(8'h30, {mx, 1'b0, ix}, "page worst");
    chk({4'h0, flags}, {4'h0, old}, "flags after load");
    thr = t;
    bufrd = 1'b1;
    @(negedge core_clk);
    bufrd = 1'b0;
    thr = ~t;
    chk({4'h0, flags}, {4'h0, f}, "flags");
    rd(8'h20, {4'h0, f}, "flag register");
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic test_mixed_page();
    page(5'd0, 5'd3, 5'd9, 5'd3, 4'h4);
    $display("test mixed page done");
  endtask

  task automatic test_tied_max();
    page(5'd1, 5'd8, 5'd8, 5'd0, 4'h8);
    page(5'd9, 5'd20, 5'd2, 5'd9, 4'hF);
    $display("test tied max done");
  endtask

  task automatic test_zero_and_edges();
    page(5'd0, 5'd0, 5'd0, 5'd0, 4'h1);
    page(5'd5, 5'd4, 5'd3, 5'd31, 4'h4);
    $display("test zero and edges done");
  endtask

  // Writes are taken but leave every field as it was
  task automatic test_write_hold();
    logic [7:0] a[4] = '{8'h20, 8'h30, 8'h40, 8'h50};
    bit ok;
    foreach (a[i]) begin
      efcr_host_model_inst.write(a[i], ok);
      chk({7'h0, ok}, 8'h01, "write ack");
      if (!ok) test_done();
    end
    rd(8'h30, 8'hF3, "worst after writes");
    rd(8'h30, 8'hF3, "worst reread");
    rd(8'h40, 8'h45, "low after writes");
    rd(8'h50, 8'hF3, "high after writes");
    rd(8'h20, 8'h0B, "flags after writes");
    rd(8'h60, 8'h00, "unmapped");
    $display("test write hold done");
  endtask

  // Reset in mid-run clears everything
  task automatic test_reset();
    @(negedge core_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    chk({4'h0, flags}, 8'h00, "flags after reset");
    rd(8'h30, 8'h00, "worst after reset");
    rd(8'h40, 8'h00, "low after reset");
    rd(8'h50, 8'h00, "high after reset");
    $display("test reset done");
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    test_mixed_page();
    test_tied_max();
    test_zero_and_edges();
    test_write_hold();
    test_reset();
    test_done();
  end
endmodule
